/* File: logic/prio_pkg_buf.sv */
/*
 Constants shared by the frame priority, mirror and group registration
 block, plus the two-entry buffer that sits in the classified frame path.
 Assumes one clock, clk_sys, and an asynchronous active-low reset nrst.
*/
// Behaviour
// R1 - Destination IP match gives entry priority
// R2 - Source IP match gives entry priority
// R3 - Either-direction IP match gives entry priority
// R4 - Priorities are three bits, 7 highest
// R5 - Ports 1 to 26 hold default priority
// R6 - Regeneration rewrites egress priority through table
// R7 - Copy mirrored frames to target, forwarding untouched
// R8 - Per-port mirror select: rx, tx, both, none
// R9 - Mirror copies dropped when target cannot keep up
// R10 - Ineligible or target port refuses mirror enable
// R11 - Software mirrors at most three ports; the block sets no limit on how many ports mirror
// R12 - Global GMRP enable gates all registration
// R13 - Per-port GMRP state, ports 1 to 28
// R14 - Per-VLAN GMRP support, VIDs 1 to 4094
// R15 - Join adds port, leave removes port
// R16 - Priority pairs map onto four queues
// R17 - Strict priority egress scheduling
// R18 - Unclassified frames get priority 0
// R19 - IP match beats port default
package prio_pkg;
   localparam int ADDR_W = 8;
   localparam int PRI_W = 3;
   localparam int Q_W = 2;
   localparam int N_QUEUES = 4;
   localparam int N_PRI_PORTS = 26;
   localparam int N_PORTS = 28;
   localparam int PORT_W = 5;
   localparam int VID_W = 12;
   localparam int N_VIDS = 4096;
   localparam logic [VID_W-1:0] VID_MAX = 12'hFFE;
   localparam int N_IP = 4;
   localparam int N_LEVELS = 8;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] A_REGEN = 8'h04;
   localparam logic [ADDR_W-1:0] A_MIR_TGT = 8'h0C;
   localparam logic [ADDR_W-1:0] A_MIR_INELIG = 8'h10;
   localparam logic [ADDR_W-1:0] A_MIR_LO = 8'h18;
   localparam logic [ADDR_W-1:0] A_MIR_HI = 8'h1C;
   localparam logic [ADDR_W-1:0] A_GM_PORT = 8'h20;
   localparam logic [ADDR_W-1:0] A_GM_VLAN = 8'h24;
   localparam logic [ADDR_W-1:0] A_GM_GSEL = 8'h28;
   localparam logic [ADDR_W-1:0] A_GM_MEMB = 8'h2C;
   localparam logic [ADDR_W-1:0] A_MIR_DROPS = 8'h30;
   localparam logic [1:0] A_IP_PAGE = 2'h1;
   localparam logic [3:0] A_PPRI_PAGE = 4'h8;
   // Field positions
   localparam int CTRL_REGEN_BIT = 0;
   localparam int CTRL_GMRP_BIT = 1;
   localparam int IPC_MODE_LSB = 4;
   localparam int GMV_ON_BIT = 16;
   localparam int MIR_LO_PORTS = 16;
   localparam int PPRI_PER_WORD = 8;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [PORT_W-1:0] RST_MIR_TGT = 5'h01;
   // Encodings
   localparam logic [1:0] IPM_OFF = 2'h0;
   localparam logic [1:0] IPM_DST = 2'h1;
   localparam logic [1:0] IPM_SRC = 2'h2;
   localparam logic [1:0] IPM_EITHER = 2'h3;
   localparam logic [1:0] MIR_NONE = 2'h0;
   localparam logic [1:0] MIR_RX = 2'h1;
   localparam logic [1:0] MIR_TX = 2'h2;
   localparam logic [1:0] MIR_BOTH = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [PRI_W-1:0] PRI_NONE = 3'h0;
endpackage

module two_slot_buf #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;
   logic push, pop;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

/* File: logic/prio_mirror_gmrp.sv */
/*
 Frame classification, priority regeneration, queue selection, strict
 priority grant, port mirroring and GMRP group membership, with an
 AXI4-Lite register slave. Assumes frame, mirror and GMRP events come
 from switch logic on clk_sys; the target port's queue reports busy.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module prio_mirror_gmrp #(
   parameter int N_GROUPS = 8,
   parameter int GRP_W = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // AXI4-Lite slave
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [prio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [prio_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Ingress frame descriptors
   input wire logic fr_valid,
   output logic fr_ready,
   input wire logic [prio_pkg::PORT_W-1:0] fr_port,
   input wire logic [31:0] fr_src_ip,
   input wire logic [31:0] fr_dst_ip,
   // Classified frames
   output logic cls_valid,
   input wire logic cls_ready,
   output logic [prio_pkg::PORT_W-1:0] cls_port,
   output logic [prio_pkg::PRI_W-1:0] cls_pri,
   output logic [prio_pkg::PRI_W-1:0] cls_egr_pri,
   output logic [prio_pkg::Q_W-1:0] cls_queue,
   // Mirror events and copies
   input wire logic mv_valid,
   input wire logic [prio_pkg::PORT_W-1:0] mv_port,
   input wire logic mv_tx,
   input wire logic mir_busy,
   output logic mir_valid,
   output logic [prio_pkg::PORT_W-1:0] mir_port,
   output logic [prio_pkg::PORT_W-1:0] mir_src_port,
   output logic mir_tx,
   // GMRP join and leave events
   input wire logic gm_valid,
   input wire logic [prio_pkg::PORT_W-1:0] gm_port,
   input wire logic [prio_pkg::VID_W-1:0] gm_vid,
   input wire logic gm_join,
   input wire logic [GRP_W-1:0] gm_group,
   // Egress queue scheduler
   input wire logic [prio_pkg::N_QUEUES-1:0] q_nonempty,
   output logic [prio_pkg::N_QUEUES-1:0] q_grant
);
   localparam int PW = prio_pkg::PRI_W;
   localparam int NP = prio_pkg::N_PORTS;
   localparam int BUF_W = prio_pkg::PORT_W + 2 * PW + prio_pkg::Q_W;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // Registers
   logic regen_en_q, gmrp_en_q;
   logic [PW-1:0] regen_q [prio_pkg::N_LEVELS];
   logic [31:0] ip_addr_q [prio_pkg::N_IP];
   logic [PW-1:0] ip_pri_q [prio_pkg::N_IP];
   logic [1:0] ip_mode_q [prio_pkg::N_IP];
   logic [PW-1:0] port_pri_q [prio_pkg::N_PRI_PORTS];
   logic [prio_pkg::PORT_W-1:0] mir_tgt_q;
   logic [NP-1:0] mir_inelig_q, gm_port_en_q;
   logic [2*NP-1:0] mir_mode_q;
   logic gm_vlan_q [prio_pkg::N_VIDS];
   logic [prio_pkg::VID_W-1:0] gm_vsel_q;
   logic [GRP_W-1:0] gm_gsel_q;
   logic [NP-1:0] member_q [N_GROUPS];
   logic [31:0] drops_q;

   // AXI write path: address and data accepted in either order
   logic aw_hold_q, w_hold_q, bvalid_q;
   logic [prio_pkg::ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q, cur_w, wr_val;
   logic [3:0] w_strb_q;
   logic wr_en, wr_ok, rvalid_q;
   logic [31:0] rdata_q, rd_val;
   logic [1:0] bresp_q, rresp_q;
   logic rd_ok;

   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready = !w_hold_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= 4'h0;
         bresp_q <= prio_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
         end
      end
   end

   // Register read view, shared by reads and by byte-lane merging
   function automatic logic [32:0] view(input logic [7:0] a);
      logic [32:0] v;
      v = {1'b1, prio_pkg::RST_ZERO};
      if (a[7:6] == prio_pkg::A_IP_PAGE && a[5] == 1'b0) begin
         if (a[2]) begin
            v[prio_pkg::IPC_MODE_LSB +: 2] = ip_mode_q[a[4:3]];
            v[PW-1:0] = ip_pri_q[a[4:3]];
         end else begin
            v[31:0] = ip_addr_q[a[4:3]];
         end
      end else if (a[7:4] == prio_pkg::A_PPRI_PAGE) begin
         for (int m = 0; m < prio_pkg::PPRI_PER_WORD; m++) begin
            if (32'(a[3:2]) * 8 + m < prio_pkg::N_PRI_PORTS)
               v[PW*m +: PW] = port_pri_q[32'(a[3:2]) * 8 + m];
         end
      end else begin
         case (a)
            prio_pkg::A_CTRL: begin
               v[prio_pkg::CTRL_REGEN_BIT] = regen_en_q;
               v[prio_pkg::CTRL_GMRP_BIT] = gmrp_en_q;
            end
            prio_pkg::A_REGEN: begin
               for (int l = 0; l < prio_pkg::N_LEVELS; l++)
                  v[PW*l +: PW] = regen_q[l];
            end
            prio_pkg::A_MIR_TGT: v[prio_pkg::PORT_W-1:0] = mir_tgt_q;
            prio_pkg::A_MIR_INELIG: v[NP-1:0] = mir_inelig_q;
            prio_pkg::A_MIR_LO: v[31:0] = mir_mode_q[31:0];
            prio_pkg::A_MIR_HI: v[2*NP-33:0] = mir_mode_q[2*NP-1:32];
            prio_pkg::A_GM_PORT: v[NP-1:0] = gm_port_en_q;
            prio_pkg::A_GM_VLAN: begin
               v[prio_pkg::VID_W-1:0] = gm_vsel_q;
               v[prio_pkg::GMV_ON_BIT] = gm_vlan_q[gm_vsel_q];
            end
            prio_pkg::A_GM_GSEL: v[GRP_W-1:0] = gm_gsel_q;
            prio_pkg::A_GM_MEMB: v[NP-1:0] = member_q[gm_gsel_q];
            prio_pkg::A_MIR_DROPS: v[31:0] = drops_q;
            default: v[32] = 1'b0;
         endcase
      end
      return v;
   endfunction

   always_comb begin
      {wr_ok, cur_w} = view(aw_addr_q);
      {rd_ok, rd_val} = view(s_axi_araddr);
   end
   assign wr_val = merge(cur_w, w_data_q, w_strb_q);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rdata_q <= prio_pkg::RST_ZERO;
         rresp_q <= prio_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_ok ? rd_val : prio_pkg::RST_ZERO;
         rresp_q <= rd_ok ? prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Priority configuration
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regen_en_q <= 1'b0;
         for (int l = 0; l < prio_pkg::N_LEVELS; l++)
            regen_q[l] <= PW'(l);
         for (int i = 0; i < prio_pkg::N_IP; i++) begin
            ip_addr_q[i] <= prio_pkg::RST_ZERO;
            ip_pri_q[i] <= prio_pkg::PRI_NONE;
            ip_mode_q[i] <= prio_pkg::IPM_OFF;
         end
         for (int p = 0; p < prio_pkg::N_PRI_PORTS; p++)
            port_pri_q[p] <= prio_pkg::PRI_NONE;
      end else if (wr_en && wr_ok) begin
         if (aw_addr_q == prio_pkg::A_CTRL)
            regen_en_q <= wr_val[prio_pkg::CTRL_REGEN_BIT];
         if (aw_addr_q == prio_pkg::A_REGEN) begin
            for (int l = 0; l < prio_pkg::N_LEVELS; l++)
               regen_q[l] <= wr_val[PW*l +: PW]; // see R6
         end
         if (aw_addr_q[7:6] == prio_pkg::A_IP_PAGE) begin
            if (aw_addr_q[2]) begin
               ip_pri_q[aw_addr_q[4:3]] <= wr_val[PW-1:0]; // see R4
               ip_mode_q[aw_addr_q[4:3]] <=
                  wr_val[prio_pkg::IPC_MODE_LSB +: 2];
            end else begin
               ip_addr_q[aw_addr_q[4:3]] <= wr_val;
            end
         end
         if (aw_addr_q[7:4] == prio_pkg::A_PPRI_PAGE) begin
            for (int m = 0; m < prio_pkg::PPRI_PER_WORD; m++) begin
               if (32'(aw_addr_q[3:2]) * 8 + m < prio_pkg::N_PRI_PORTS)
                  port_pri_q[32'(aw_addr_q[3:2]) * 8 + m] <=
                     wr_val[PW*m +: PW]; // see R5
            end
         end
      end
   end

   // Classification: lowest matching IP entry, then port default, else 0
   logic ip_hit;
   logic [PW-1:0] ip_pri, port_pri, pri_d, egr_d;
   always_comb begin
      ip_hit = 1'b0;
      ip_pri = prio_pkg::PRI_NONE;
      for (int i = prio_pkg::N_IP - 1; i >= 0; i--) begin
         if ((ip_mode_q[i] == prio_pkg::IPM_DST &&
               fr_dst_ip == ip_addr_q[i]) || // see R1
             (ip_mode_q[i] == prio_pkg::IPM_SRC &&
               fr_src_ip == ip_addr_q[i]) || // see R2
             (ip_mode_q[i] == prio_pkg::IPM_EITHER &&
               (fr_src_ip == ip_addr_q[i] ||
                fr_dst_ip == ip_addr_q[i]))) begin // see R3
            ip_hit = 1'b1;
            ip_pri = ip_pri_q[i];
         end
      end
      port_pri = prio_pkg::PRI_NONE; // see R18
      if (fr_port >= 5'h01 && 32'(fr_port) <= prio_pkg::N_PRI_PORTS)
         port_pri = port_pri_q[fr_port - 5'h01]; // see R5
      pri_d = ip_hit ? ip_pri : port_pri; // see R19
      egr_d = regen_en_q ? regen_q[pri_d] : pri_d; // see R6
   end

   // Buffer holds frames while the downstream stalls
   two_slot_buf #(.W(BUF_W)) u_buf (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(fr_valid),
      .in_ready(fr_ready),
      .in_data({fr_port, pri_d, egr_d, pri_d[PW-1:1]}), // see R16
      .out_valid(cls_valid),
      .out_ready(cls_ready),
      .out_data({cls_port, cls_pri, cls_egr_pri, cls_queue})
   );

   // Strict priority: highest nonempty queue wins
   always_comb begin
      q_grant = '0;
      for (int q = 0; q < prio_pkg::N_QUEUES; q++) begin
         if (q_nonempty[q]) q_grant = prio_pkg::N_QUEUES'(1 << q); // see R17
      end
   end

   // Mirror configuration; refused ports keep their old setting
   logic [2*NP-1:0] mir_new, mir_lock;
   always_comb begin
      mir_new = mir_mode_q;
      if (aw_addr_q == prio_pkg::A_MIR_LO) mir_new[31:0] = wr_val;
      if (aw_addr_q == prio_pkg::A_MIR_HI)
         mir_new[2*NP-1:32] = wr_val[2*NP-33:0];
      for (int p = 0; p < NP; p++) begin
         mir_lock[2*p +: 2] = {2{mir_inelig_q[p] ||
            32'(mir_tgt_q) == p + 1}};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mir_tgt_q <= prio_pkg::RST_MIR_TGT;
         mir_inelig_q <= '0;
         mir_mode_q <= '0;
      end else if (wr_en && wr_ok) begin
         if (aw_addr_q == prio_pkg::A_MIR_TGT)
            mir_tgt_q <= wr_val[prio_pkg::PORT_W-1:0];
         if (aw_addr_q == prio_pkg::A_MIR_INELIG)
            mir_inelig_q <= wr_val[NP-1:0];
         mir_mode_q <= (mir_new & ~mir_lock) |
            (mir_mode_q & mir_lock); // see R10
      end
   end

   // Mirror copies: the original frame path is never touched
   logic [1:0] mv_mode;
   logic mv_match;
   assign mv_mode = (mv_port >= 5'h01 && 32'(mv_port) <= NP) ?
      mir_mode_q[2*(mv_port - 5'h01) +: 2] : prio_pkg::MIR_NONE;
   assign mv_match = mv_valid && mv_port != mir_tgt_q &&
      (mv_mode == prio_pkg::MIR_BOTH ||
       mv_mode == (mv_tx ? prio_pkg::MIR_TX : prio_pkg::MIR_RX)); // see R8

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mir_valid <= 1'b0;
         mir_port <= '0;
         mir_src_port <= '0;
         mir_tx <= 1'b0;
         drops_q <= prio_pkg::RST_ZERO;
      end else begin
         mir_valid <= mv_match && !mir_busy; // see R7
         if (mv_match && !mir_busy) begin
            mir_port <= mir_tgt_q;
            mir_src_port <= mv_port;
            mir_tx <= mv_tx;
         end
         // A slow target cannot absorb every copy; count what is lost
         if (mv_match && mir_busy) drops_q <= drops_q + 32'h1; // see R9
      end
   end

   // GMRP configuration and membership
   logic gm_ok;
   assign gm_ok = gm_valid && gmrp_en_q && // see R12
      gm_port >= 5'h01 && 32'(gm_port) <= NP &&
      gm_port_en_q[gm_port - 5'h01] && // see R13
      gm_vlan_q[gm_vid] && 32'(gm_group) < N_GROUPS; // see R14

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gmrp_en_q <= 1'b0;
         gm_port_en_q <= '0;
         gm_vsel_q <= '0;
         gm_gsel_q <= '0;
         for (int v = 0; v < prio_pkg::N_VIDS; v++) gm_vlan_q[v] <= 1'b0;
      end else if (wr_en && wr_ok) begin
         if (aw_addr_q == prio_pkg::A_CTRL)
            gmrp_en_q <= wr_val[prio_pkg::CTRL_GMRP_BIT];
         if (aw_addr_q == prio_pkg::A_GM_PORT)
            gm_port_en_q <= wr_val[NP-1:0];
         if (aw_addr_q == prio_pkg::A_GM_GSEL)
            gm_gsel_q <= wr_val[GRP_W-1:0];
         if (aw_addr_q == prio_pkg::A_GM_VLAN) begin
            gm_vsel_q <= wr_val[prio_pkg::VID_W-1:0];
            // VID 0 and 4095 are reserved and stay off
            if (wr_val[prio_pkg::VID_W-1:0] != '0 &&
                wr_val[prio_pkg::VID_W-1:0] <= prio_pkg::VID_MAX)
               gm_vlan_q[wr_val[prio_pkg::VID_W-1:0]] <=
                  wr_val[prio_pkg::GMV_ON_BIT]; // see R14
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int g = 0; g < N_GROUPS; g++) member_q[g] <= '0;
      end else if (gm_ok) begin
         member_q[gm_group][gm_port - 5'h01] <= gm_join; // see R15
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence s_gm_join;
      gm_ok && gm_join ##1 1'b1;
   endsequence

   a_queue_pairing: assert property ( // see R16
      cls_valid |-> cls_queue == cls_pri[2:1])
      else $error("queue does not follow priority pair");
   a_regen_table: assert property ( // see R6
      fr_valid && fr_ready && regen_en_q && $stable(regen_q[pri_d])
      |=> u_buf.mem_q[$past(u_buf.wp_q)][prio_pkg::Q_W +: PW] ==
         $past(regen_q[pri_d]))
      else $error("egress priority not regenerated");
   a_strict_grant: assert property ( // see R17
      q_nonempty[3] |-> q_grant == 4'h8)
      else $error("highest queue not granted");
   a_mirror_copy: assert property ( // see R7
      mv_match && !mir_busy |=> mir_valid && mir_port == $past(mir_tgt_q))
      else $error("mirror copy missing or misdirected");
   a_mirror_drop: assert property ( // see R9
      mv_match && mir_busy |=> !mir_valid && drops_q == $past(drops_q) + 1)
      else $error("busy target copy not dropped and counted");
   a_mirror_refuse: assert property ( // see R10
      wr_en |=> ((mir_mode_q ^ $past(mir_mode_q)) & $past(mir_lock)) == '0)
      else $error("ineligible port mirror setting changed");
   a_gmrp_gated: assert property ( // see R12
      gm_valid && !gmrp_en_q |=>
      member_q[$past(gm_group)] == $past(member_q[gm_group]))
      else $error("membership changed while gated");
   a_gmrp_join: assert property ( // see R15
      s_gm_join |-> member_q[$past(gm_group)][$past(gm_port) - 5'h01])
      else $error("joined port not registered");
   a_unclassified: assert property ( // see R18
      fr_valid && !ip_hit && (fr_port == 5'h00 || fr_port > 5'h1A)
      |-> pri_d == prio_pkg::PRI_NONE)
      else $error("unclassified frame not priority 0");
endmodule

/* File: tb/analyzer_model.sv */
/*
 Analyzer behind the mirror target port: counts copies, stalls on demand.
 Assumes the bench raises stall only between mirror events.
*/
module analyzer_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Copy port and stall request
   input wire logic mir_valid,
   input wire logic stall,
   output logic mir_busy,
   output int copies
);
   timeunit 1ns;
   timeprecision 1ps;
   // A slow analyzer cannot take copies while stalled
   assign mir_busy = stall;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) copies <= 0;
      else if (mir_valid) copies <= copies + 1;
   end
endmodule

/* File: tb/test_frame_priority_mirror_gmrp.sv */
/*
 Self-checking bench for the priority, mirror and GMRP block.
 Assumes the analyzer model stands on the mirror copy port.
*/
module test_frame_priority_mirror_gmrp;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] IPA = 32'h0A00_0001, IPB = 32'h0A00_0002;
   localparam logic [31:0] IPC = 32'h0A00_0003, IPX = 32'h0A00_0009;
   logic clk_sys = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, fr_valid = 0, cls_ready = 0, mv_valid = 0;
   logic mv_tx = 0, stall = 0, gm_valid = 0, gm_join = 0, mir_busy;
   logic awready, wready, bvalid, arready, rvalid, fr_ready, cls_valid;
   logic mir_valid, mir_tx;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, fr_src_ip = 0, fr_dst_ip = 0, d;
   logic [3:0] wstrb = 0, q_nonempty = 0, q_grant;
   logic [1:0] bresp, rresp, cls_queue, r;
   logic [4:0] fr_port = 0, mv_port = 0, gm_port = 0;
   logic [4:0] cls_port, mir_port, mir_src_port;
   logic [2:0] cls_pri, cls_egr_pri, gm_group = 0;
   logic [11:0] gm_vid = 0;
   int error_cnt = 0, tests_run = 0, copies, n;
   always #2.5 clk_sys = ~clk_sys;
   prio_mirror_gmrp u_prio_mirror_gmrp (.clk_sys, .nrst,
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .fr_valid, .fr_ready, .fr_port,
      .fr_src_ip, .fr_dst_ip, .cls_valid, .cls_ready, .cls_port, .cls_pri,
      .cls_egr_pri, .cls_queue, .mv_valid, .mv_port, .mv_tx, .mir_busy,
      .mir_valid, .mir_port, .mir_src_port, .mir_tx, .gm_valid, .gm_port,
      .gm_vid, .gm_join, .gm_group, .q_nonempty, .q_grant);
   analyzer_model u_analyzer_model (.clk_sys, .nrst, .mir_valid, .stall,
      .mir_busy, .copies);
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo;
      if (n >= 40) begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= v;
      wstrb <= 4'hF; bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      tmo();
      r = bresp;
      bready <= 0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a);
      arvalid <= 1; araddr <= a; rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      tmo();
      d = rdata;
      r = rresp;
      rready <= 0;
      @(posedge clk_sys);
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      rd(a);
      chk(nm, d, e);
   endtask
   task automatic frm(input logic [4:0] p, input logic [31:0] s, t,
      input logic [2:0] ep, eg);
      fr_valid <= 1; fr_port <= p; fr_src_ip <= s; fr_dst_ip <= t;
      cls_ready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (fr_ready) break;
      end
      tmo();
      fr_valid <= 0;
      @(posedge clk_sys);
      chk("cls_port", {cls_valid, cls_port}, {1'b1, p});
      chk("cls_pri", cls_pri, ep);
      chk("cls_egr_pri", cls_egr_pri, eg);
      chk("cls_queue", cls_queue, ep[2:1]);
   endtask
   task automatic t_regs;
      rchk("ctrl", prio_pkg::A_CTRL, 0);
      rchk("regen", prio_pkg::A_REGEN, 32'h00FA_C688);
      rchk("mir_tgt", prio_pkg::A_MIR_TGT, 1);
      rd(8'h08);
      chk("unmapped_rd", r, prio_pkg::RESP_SLVERR);
      wr(8'h08, 32'hFFFF_FFFF);
      chk("unmapped_wr", r, prio_pkg::RESP_SLVERR);
      wr(prio_pkg::A_MIR_DROPS, 32'h5);
      rchk("drops_ro", prio_pkg::A_MIR_DROPS, 0);
   endtask
   task automatic t_class;
      wr(8'h40, IPA); wr(8'h44, 32'h16);
      wr(8'h48, IPB); wr(8'h4C, 32'h23);
      wr(8'h50, IPC); wr(8'h54, 32'h35);
      wr(8'h80, 32'h20);
      frm(2, IPX, IPA, 6, 6);
      frm(1, IPA, IPX, 0, 0);
      frm(1, IPB, IPX, 3, 3);
      frm(1, IPX, IPB, 0, 0);
      frm(1, IPC, IPX, 5, 5);
      frm(1, IPX, IPC, 5, 5);
      frm(2, IPX, IPX, 4, 4);
   endtask
   task automatic t_regen;
      logic [31:0] t = 0;
      for (int l = 0; l < 8; l++) t[3*l +: 3] = 3'(7 - l);
      wr(prio_pkg::A_REGEN, t); wr(prio_pkg::A_CTRL, 1);
      frm(2, IPX, IPA, 6, 1);
      frm(27, IPX, IPX, 0, 7);
   endtask
   task automatic t_buf;
      cls_ready <= 0; fr_valid <= 1; fr_port <= 2;
      repeat (3) @(posedge clk_sys);
      chk("fr_ready_full", fr_ready, 0);
      fr_valid <= 0; cls_ready <= 1;
      repeat (2) @(posedge clk_sys);
      chk("second_pri", cls_pri, 4);
      @(posedge clk_sys);
      chk("drained", cls_valid, 0);
   endtask
   task automatic mv(input logic [4:0] p, input logic tx, e);
      mv_valid <= 1; mv_port <= p; mv_tx <= tx;
      @(posedge clk_sys);
      mv_valid <= 0;
      @(posedge clk_sys);
      chk("mir_valid", mir_valid, e);
      if (e) chk("mir_copy", {mir_port, mir_src_port, mir_tx},
         {5'h05, p, tx});
   endtask
   task automatic t_mirror;
      wr(prio_pkg::A_MIR_TGT, 5); wr(prio_pkg::A_MIR_INELIG, 32'h8);
      // Only port 3 is ever a source, well inside three ports
      wr(prio_pkg::A_MIR_LO, 32'h3D0);
      rchk("mir_lo", prio_pkg::A_MIR_LO, 32'h10);
      mv(3, 0, 1); mv(3, 1, 0); mv(4, 0, 0);
      wr(prio_pkg::A_MIR_LO, 32'h20);
      mv(3, 1, 1); mv(3, 0, 0);
      wr(prio_pkg::A_MIR_LO, 32'h30);
      mv(3, 0, 1); mv(3, 1, 1);
      stall <= 1;
      mv(3, 0, 0);
      stall <= 0;
      rchk("drops", prio_pkg::A_MIR_DROPS, 1);
      chk("copies", copies, 4);
   endtask
   task automatic gm(input logic [4:0] p, input logic j);
      gm_valid <= 1; gm_port <= p; gm_vid <= 12'h00A; gm_join <= j;
      gm_group <= 1;
      @(posedge clk_sys);
      gm_valid <= 0;
      @(posedge clk_sys);
   endtask
   task automatic t_gmrp;
      wr(prio_pkg::A_GM_GSEL, 1); wr(prio_pkg::A_GM_PORT, 32'h2);
      wr(prio_pkg::A_GM_VLAN, 32'h1_000A);
      rchk("vlan_on", prio_pkg::A_GM_VLAN, 32'h1_000A);
      gm(2, 1);
      rchk("memb_off", prio_pkg::A_GM_MEMB, 0);
      wr(prio_pkg::A_CTRL, 2);
      gm(3, 1);
      rchk("memb_port", prio_pkg::A_GM_MEMB, 0);
      gm(2, 1);
      rchk("memb_join", prio_pkg::A_GM_MEMB, 2);
      wr(prio_pkg::A_GM_VLAN, 32'h0_000A);
      gm(2, 0);
      rchk("memb_vlan", prio_pkg::A_GM_MEMB, 2);
      wr(prio_pkg::A_GM_VLAN, 32'h1_000A);
      gm(2, 0);
      rchk("memb_leave", prio_pkg::A_GM_MEMB, 0);
   endtask
   task automatic t_sched;
      logic [3:0] e;
      for (int i = 0; i < 16; i++) begin
         q_nonempty <= 4'(i);
         e = 0;
         for (int b = 0; b < 4; b++) if (i[b]) e = 4'(1 << b);
         @(posedge clk_sys);
         chk("q_grant", q_grant, e);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      t_regs(); t_class(); t_regen(); t_buf(); t_mirror(); t_gmrp(); t_sched();
      final_report();
   end
endmodule
